// file: design/pba_pkg.sv
// Overview of operation
// - the arbiter takes five requests, four from external bus masters and one from the core.
// - with the arbiter enabled, the grants for the external masters and the core come from here.
// - request 0 drives only while disabled, grant 0 is then an input, requests 3..1 never drive.
// - a strap sampled at power-up decides whether the arbiter is enabled.
// - software enables each requester and gives it high or low priority in a control register.
// - after reset the core is high priority and the four external requesters are low priority.
// - each group rotates round-robin and the whole low group is one member of the high rotation.
// - each requester sits in exactly one group and a low requester's high slot is skipped.
// - the bus parks on the core out of reset and later on the requester served last.
// - one last-served pointer per group advances whenever a new requester is granted.
// - high order is core, ext0, ext1, ext2, ext3, low group, searching after the last served.
// - at the end of a transaction requests are sampled; with none, pointers and grant stay put.
// - the winner follows rotation position only, never the order in which requests arrived.
// - a grant is withdrawn when the bus stays idle for a fixed number of cycles after it.
package pba_pkg;

    localparam int NUM_REQ = 5;
    localparam int NUM_HI_SLOTS = 6;
    localparam int IDX_W = 3;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;

    // control field positions and reset values
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_HI_LSB = 8;
    localparam logic [4:0] EN_RST = 5'h1F;
    localparam logic [4:0] HI_RST = 5'h01;

    // status field positions
    localparam int STAT_ARB_ON_BIT = 0;
    localparam int STAT_GNT_BIT = 1;
    localparam int STAT_OWNER_LSB = 4;
    localparam int STAT_HPTR_LSB = 8;
    localparam int STAT_LPTR_LSB = 12;
    localparam int STAT_REQ_LSB = 16;

    // requester and slot indices, pointer reset values
    localparam logic [2:0] CORE_IDX = 3'h0;
    localparam logic [2:0] LOW_SLOT = 3'h5;
    localparam logic [2:0] HPTR_RST = 3'h0;
    localparam logic [2:0] LPTR_RST = 3'h4;

    // idle cycles before a grant is withdrawn
    localparam int IDLE_M_DEF = 16;
    localparam int IDLE_CNT_W = 16;

    typedef struct packed {
        logic [4:0] high;
        logic [4:0] enable;
    } pba_ctrl_t;

    typedef enum logic [2:0] {
        S_GNT = 3'b001,
        S_GAP = 3'b010,
        S_OFF = 3'b100
    } pba_state_t;

endpackage : pba_pkg

// file: design/pba_rr_pick.sv
`timescale 1ns/1ns
module pba_rr_pick #(
    parameter int N = 6,
    parameter int W = 3
) (
    input wire logic [N-1:0] req_i,  // eligible requests
    input wire logic [W-1:0] last_i, // last served slot
    output logic valid_o,            // some request present
    output logic [W-1:0] win_o       // first slot after last_i
);

    // nearest slot is visited last so it overwrites farther hits
    always_comb begin
        int idx;
        idx = 0;
        valid_o = |req_i;
        win_o = '0;
        for (int k = N; k >= 1; k--) begin
            idx = (int'(last_i) + k) % N;
            if (req_i[idx]) begin
                win_o = W'(idx);
            end
        end
    end

endmodule : pba_rr_pick

// file: design/pba_arbiter.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module pba_arbiter #(
    parameter int IDLE_M = pba_pkg::IDLE_M_DEF
) (
    input wire logic sys_clk_i,                 // bus clock
    input wire logic reset_n_i,                 // sync reset, low
    input wire logic arbiter_powerup_strap_i,   // high enables arbiter
    // core side
    input wire logic core_req_i,                // core wants the bus
    output logic core_gnt_o,                    // core owns the bus
    // bus pins
    input wire logic [3:0] pci_req_n_i,         // request pins in
    output logic [3:0] pci_req_n_o,             // request pins out
    output logic [3:0] pci_req_n_oe_n_o,        // request drive, low
    input wire logic [3:0] pci_gnt_n_i,         // grant pins in
    output logic [3:0] pci_gnt_n_o,             // grant pins out
    output logic [3:0] pci_gnt_n_oe_n_o,        // grant drive, low
    input wire logic pci_frame_n_i,             // frame, low
    input wire logic pci_irdy_n_i,              // initiator ready, low
    // apb slave
    input wire logic [7:0] paddr_i,             // byte address
    input wire logic psel_i,                    // select
    input wire logic penable_i,                 // access phase
    input wire logic pwrite_i,                  // write
    input wire logic [31:0] pwdata_i,           // write data
    output logic [31:0] prdata_o,               // read data
    output logic pready_o,                      // ready
    output logic pslverr_o                      // unmapped address
);

    localparam int IW = pba_pkg::IDX_W;
    localparam int CW = pba_pkg::IDLE_CNT_W;
    localparam logic [CW-1:0] IDLE_LAST = CW'(IDLE_M - 1);

    // ---------------- state ----------------
    logic strap_r;
    pba_pkg::pba_ctrl_t ctrl_r;
    pba_pkg::pba_state_t state_r;
    pba_pkg::pba_state_t state_nxt;
    logic [IW-1:0] owner_r;
    logic [IW-1:0] owner_nxt;
    logic [IW-1:0] hptr_r;
    logic [IW-1:0] hptr_nxt;
    logic [IW-1:0] lptr_r;
    logic [IW-1:0] lptr_nxt;
    logic [CW-1:0] idle_cnt_r;
    logic [CW-1:0] idle_cnt_nxt;
    logic [4:0] gnt_r;
    logic [4:0] gnt_nxt;
    logic core_gnt_r;
    logic core_gnt_nxt;
    logic [3:0] req_out_r;
    logic [3:0] req_oe_n_r;
    logic [3:0] gnt_oe_n_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // ---------------- request shaping ----------------
    wire [4:0] req_raw;
    wire [4:0] req_ok;
    wire [4:0] req_hi;
    wire [4:0] req_lo;
    wire [5:0] hi_slots;

    assign req_raw = {~pci_req_n_i, core_req_i};
    assign req_ok = req_raw & ctrl_r.enable;
    // one bit decides the group, so a requester can never sit in both
    assign req_hi = req_ok & ctrl_r.high;
    assign req_lo = req_ok & ~ctrl_r.high;
    // the low group stands in a single slot after ext3
    assign hi_slots = {|req_lo, req_hi};

    // ---------------- round robin ----------------
    wire hi_valid;
    wire [IW-1:0] hi_win;
    wire lo_valid;
    wire [IW-1:0] lo_win;
    wire [IW-1:0] win_req;

    pba_rr_pick #(
        .N(pba_pkg::NUM_HI_SLOTS),
        .W(IW)
    ) u_hi_pick (
        .req_i(hi_slots),
        .last_i(hptr_r),
        .valid_o(hi_valid),
        .win_o(hi_win)
    );

    pba_rr_pick #(
        .N(pba_pkg::NUM_REQ),
        .W(IW)
    ) u_lo_pick (
        .req_i(req_lo),
        .last_i(lptr_r),
        .valid_o(lo_valid),
        .win_o(lo_win)
    );

    // winner depends on slot position only, not on arrival time
    assign win_req = (hi_win == pba_pkg::LOW_SLOT) ? lo_win : hi_win;

    // ---------------- bus observation ----------------
    wire bus_idle;
    wire owner_req;
    wire timeout;
    wire arb_fire;
    wire in_gnt;
    wire in_off;

    assign bus_idle = pci_frame_n_i & pci_irdy_n_i;
    assign owner_req = req_ok[owner_r];
    assign timeout = (idle_cnt_r == IDLE_LAST);
    assign in_gnt = (state_r == pba_pkg::S_GNT);
    assign in_off = (state_r == pba_pkg::S_OFF);
    // sample requests once the owner is done and the bus has gone idle
    assign arb_fire = bus_idle & ((in_gnt & (~owner_req | timeout)) | in_off);

    // ---------------- next state ----------------
    always_comb begin
        state_nxt = state_r;
        owner_nxt = owner_r;
        hptr_nxt = hptr_r;
        lptr_nxt = lptr_r;
        unique case (state_r)
            pba_pkg::S_GNT: begin
                if (arb_fire && hi_valid) begin
                    // grant moves, with one dead cycle for turnaround
                    state_nxt = pba_pkg::S_GAP;
                    owner_nxt = win_req;
                    hptr_nxt = hi_win;
                    if (hi_win == pba_pkg::LOW_SLOT) begin
                        lptr_nxt = lo_win;
                    end
                end else if (arb_fire && timeout) begin
                    state_nxt = pba_pkg::S_OFF;
                end
                // no request: stay parked, pointers untouched
            end
            pba_pkg::S_GAP: begin
                state_nxt = pba_pkg::S_GNT;
            end
            pba_pkg::S_OFF: begin
                if (arb_fire && hi_valid) begin
                    state_nxt = pba_pkg::S_GAP;
                    owner_nxt = win_req;
                    hptr_nxt = hi_win;
                    if (hi_win == pba_pkg::LOW_SLOT) begin
                        lptr_nxt = lo_win;
                    end
                end
            end
        endcase
    end

    // idle cycles are counted only while a grant is standing
    assign idle_cnt_nxt = (in_gnt && bus_idle && state_nxt == pba_pkg::S_GNT)
                          ? idle_cnt_r + CW'(1) : '0;

    // ---------------- grant drive ----------------
    wire gnt_live;
    wire [4:0] gnt_onehot;

    assign gnt_live = strap_r & (state_nxt == pba_pkg::S_GNT);
    assign gnt_onehot = 5'h01 << owner_nxt;
    assign gnt_nxt = gnt_live ? gnt_onehot : 5'h00;
    // disabled: the core's grant comes from the outside arbiter on grant 0
    assign core_gnt_nxt = strap_r ? gnt_nxt[0] : ~pci_gnt_n_i[0];

    // ---------------- apb decode ----------------
    wire apb_setup;
    wire hit_ctrl;
    wire hit_stat;
    wire apb_hit;
    wire wr_fire;
    wire [31:0] ctrl_word;
    wire [31:0] stat_word;
    wire [31:0] rd_word;

    assign apb_setup = psel_i & ~penable_i;
    assign hit_ctrl = (paddr_i == pba_pkg::CTRL_OFF);
    assign hit_stat = (paddr_i == pba_pkg::STAT_OFF);
    assign apb_hit = hit_ctrl | hit_stat;
    assign wr_fire = psel_i & penable_i & pready_r & pwrite_i & hit_ctrl;

    assign ctrl_word = (32'(ctrl_r.enable) << pba_pkg::CTRL_EN_LSB)
                     | (32'(ctrl_r.high) << pba_pkg::CTRL_HI_LSB);
    assign stat_word = (32'(strap_r) << pba_pkg::STAT_ARB_ON_BIT)
                     | (32'(|gnt_r) << pba_pkg::STAT_GNT_BIT)
                     | (32'(owner_r) << pba_pkg::STAT_OWNER_LSB)
                     | (32'(hptr_r) << pba_pkg::STAT_HPTR_LSB)
                     | (32'(lptr_r) << pba_pkg::STAT_LPTR_LSB)
                     | (32'(req_raw) << pba_pkg::STAT_REQ_LSB);
    assign rd_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

    // ---------------- flops ----------------
    // strap is caught while reset is held, not through a reset value
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            strap_r <= arbiter_powerup_strap_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ctrl_r.enable <= pba_pkg::EN_RST;
            ctrl_r.high <= pba_pkg::HI_RST;
        end else if (wr_fire) begin
            ctrl_r.enable <= pwdata_i[pba_pkg::CTRL_EN_LSB +: 5];
            ctrl_r.high <= pwdata_i[pba_pkg::CTRL_HI_LSB +: 5];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_r <= pba_pkg::S_GNT;
            owner_r <= pba_pkg::CORE_IDX;
            hptr_r <= pba_pkg::HPTR_RST;
            lptr_r <= pba_pkg::LPTR_RST;
            idle_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            owner_r <= owner_nxt;
            hptr_r <= hptr_nxt;
            lptr_r <= lptr_nxt;
            idle_cnt_r <= idle_cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            gnt_r <= 5'h00;
            core_gnt_r <= 1'b0;
            req_out_r <= 4'hF;
            req_oe_n_r <= 4'hF;
            gnt_oe_n_r <= 4'hF;
        end else begin
            gnt_r <= gnt_nxt;
            core_gnt_r <= core_gnt_nxt;
            req_out_r <= {3'h7, ~core_req_i};
            // requests 3..1 never drive; request 0 only for an outside arbiter
            req_oe_n_r <= {3'h7, strap_r};
            // grant pins drive only when this arbiter owns them
            gnt_oe_n_r <= {4{~strap_r}};
        end
    end

    // zero wait states: pready rises in the first access cycle
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~apb_hit;
            if (apb_setup) begin
                prdata_r <= pwrite_i ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // ---------------- outputs ----------------
    assign core_gnt_o = core_gnt_r;
    assign pci_req_n_o = req_out_r;
    assign pci_req_n_oe_n_o = req_oe_n_r;
    assign pci_gnt_n_o = ~gnt_r[4:1];
    assign pci_gnt_n_oe_n_o = gnt_oe_n_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

endmodule : pba_arbiter

// file: verif/pba_monitor.sv
`timescale 1ns/1ns
module pba_monitor #(
    parameter int IDLE_M = 16
) (
    input wire logic sys_clk_i, // clock
    input wire logic reset_n_i, // sync reset
    input wire logic arbiter_powerup_strap_i, // strap
    input wire logic core_req_i, // core request
    input wire logic core_gnt_o, // core grant
    input wire logic [3:0] pci_req_n_i, // request pins
    input wire logic [3:0] pci_req_n_o, // request out
    input wire logic [3:0] pci_req_n_oe_n_o, // request drive
    input wire logic [3:0] pci_gnt_n_i, // grant pins
    input wire logic [3:0] pci_gnt_n_o, // grant out
    input wire logic [3:0] pci_gnt_n_oe_n_o, // grant drive
    input wire logic pci_frame_n_i, // frame
    input wire logic pci_irdy_n_i, // ready
    input wire logic [7:0] paddr_i, // address
    input wire logic psel_i, // select
    input wire logic penable_i, // access
    input wire logic pready_o, // ready
    input wire logic pslverr_o // error
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    wire logic [4:0] g = {~pci_gnt_n_o, core_gnt_o};
    wire logic arb_on = pci_req_n_oe_n_o[0];
    // any raw request counts as competition, so this bound is never tighter than the design's
    wire logic quiet = pci_frame_n_i && pci_irdy_n_i && pci_req_n_i == 4'hF && !core_req_i;
    logic [7:0] idle_r;
    always_ff @(posedge sys_clk_i) begin
        idle_r <= (!reset_n_i || g == 5'h00 || !quiet) ? 8'h00 : idle_r + 8'h01;
    end
    sequence s_setup; psel_i && !penable_i; endsequence
    property p_ready; s_setup |=> pready_o ##1 !pready_o; endproperty
    a_ready: assert property (p_ready) else $error("ready is not one pulse");
    property p_unmap; (s_setup and (paddr_i != 8'h00 && paddr_i != 8'h04))
        |=> pslverr_o; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access without error");
    property p_req_oe; $past(reset_n_i) |-> pci_req_n_oe_n_o[3:1] == 3'h7; endproperty
    a_req_oe: assert property (p_req_oe) else $error("upper request pins driven");
    property p_gnt_oe; $past(reset_n_i) |-> pci_gnt_n_oe_n_o == {4{~arb_on}}; endproperty
    a_gnt_oe: assert property (p_gnt_oe) else $error("grant drive disagrees with mode");
    property p_strap; $rose(reset_n_i) |=> arb_on == $past(arbiter_powerup_strap_i, 2); endproperty
    a_strap: assert property (p_strap) else $error("mode not taken from strap");
    property p_one; arb_on |-> $onehot0(g); endproperty
    a_one: assert property (p_one) else $error("two grants at once");
    property p_gap; g != 5'h00 && g != $past(g) |-> $past(g) == 5'h00; endproperty
    a_gap: assert property (p_gap) else $error("grant moved without a gap");
    property p_won; pci_gnt_n_o != 4'hF && $past(pci_gnt_n_o) == 4'hF
        |-> (~$past(pci_req_n_i, 2) & ~pci_gnt_n_o) != 4'h0; endproperty
    a_won: assert property (p_won) else $error("grant to a silent master");
    property p_ext; !arb_on && !$past(arb_on)
        |-> core_gnt_o == !$past(pci_gnt_n_i[0]); endproperty
    a_ext: assert property (p_ext) else $error("core grant not from pin");
    property p_idle; idle_r <= IDLE_M + 2; endproperty
    a_idle: assert property (p_idle) else $error("idle grant kept too long");
    property p_park; $rose(reset_n_i) && arbiter_powerup_strap_i
        |-> ##[1:3] core_gnt_o; endproperty
    a_park: assert property (p_park) else $error("no park on core");
endmodule : pba_monitor
bind pba_arbiter pba_monitor #(.IDLE_M(IDLE_M)) pba_monitor_i (.*);

// file: verif/pba_bus_model.sv
`timescale 1ns/1ns
module pba_bus_model (
    input wire logic clk_i, // bus clock
    input wire logic [4:0] want_i, // work pending, core first
    input wire logic [4:0] gnt_i, // grants, active high
    input wire logic [1:0] lag_i, // granted idle edges waited first
    output logic [4:0] req_o, // requests, active high
    output logic frame_n_o = 1'b1, // frame, pulled up
    output logic irdy_n_o = 1'b1 // ready, pulled up
);
    logic [4:0] done_r = 5'h00;
    logic [1:0] wait_r = 2'h0;
    logic [1:0] beat_r = 2'h0;
    wire logic go = (gnt_i & req_o) != 5'h00 && frame_n_o && irdy_n_o && beat_r == 2'h0;
    assign req_o = want_i & ~done_r;
    always @(posedge clk_i) begin
        done_r <= done_r & want_i;
        frame_n_o <= 1'b1;
        irdy_n_o <= beat_r != 2'h2;
        beat_r <= beat_r - {1'b0, beat_r != 2'h0};
        wait_r <= go ? wait_r + 2'h1 : 2'h0;
        // request drops as frame starts: one data phase, then the bus is idle
        if (go && wait_r == lag_i) begin
            done_r <= (done_r | gnt_i) & want_i;
            frame_n_o <= 1'b0;
            beat_r <= 2'h2;
        end
    end
endmodule : pba_bus_model

// file: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int IDLE_M = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b1;
    logic [3:0] ext_gnt_n = 4'hF;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] want = 5'h00;
    logic [1:0] lag = 2'h0;
    logic [4:0] req, g_r;
    logic frame_n, irdy_n, core_gnt, pready, pslverr;
    logic [3:0] req_n_o, req_oe_n, gnt_n_o, gnt_oe_n;
    logic [31:0] prdata, r;
    logic [2:0] hp, lp, last;
    pba_pkg::pba_ctrl_t ctl;
    logic [2:0] gnt_q[$];
    logic [32:0] rd_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    int seed = 32'hCD0B7FD5;
    // pin levels resolved from the arbiter's drive enables on request 0 and the grant pins
    wire logic [3:0] req_pin = {~req[4:2], req_oe_n[0] ? ~req[1] : req_n_o[0]};
    wire logic [3:0] gnt_pin = (gnt_oe_n & ext_gnt_n) | (~gnt_oe_n & gnt_n_o);
    wire logic [4:0] g = {~(gnt_n_o | gnt_oe_n), core_gnt};
    pba_arbiter #(.IDLE_M(IDLE_M)) pba_arbiter_i (.sys_clk_i(clk), .reset_n_i(rst_n),
        .arbiter_powerup_strap_i(strap), .core_req_i(req[0]), .core_gnt_o(core_gnt),
        .pci_req_n_i(req_pin), .pci_req_n_o(req_n_o), .pci_req_n_oe_n_o(req_oe_n),
        .pci_gnt_n_i(gnt_pin), .pci_gnt_n_o(gnt_n_o), .pci_gnt_n_oe_n_o(gnt_oe_n),
        .pci_frame_n_i(frame_n), .pci_irdy_n_i(irdy_n), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr));
    pba_bus_model pba_bus_model_i (.clk_i(clk), .want_i(want), .gnt_i(g), .lag_i(lag),
        .req_o(req), .frame_n_o(frame_n), .irdy_n_o(irdy_n));
    always #4 clk = ~clk;
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        if (rst_n && g != 5'h00 && g !== g_r)
            check("grant", g, 33'h1 << gnt_q.pop_front());
        if (psel && penable && pready && !pwrite)
            check("read", {pslverr, prdata}, rd_q.pop_front());
        g_r <= g;
    end
    always @(posedge clk) if (++cyc == 20000) begin
        n_errors++;
        close_out();
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] exp);
        if (!wr) rd_q.push_back(exp);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: only the bench timeout may end a hung access
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    function automatic logic [2:0] pick(input logic [4:0] rq);
        logic [2:0] s;
        logic [4:0] lo;
        lo = rq & ctl.enable & ~ctl.high;
        s = hp;
        repeat (6) begin
            s = (s == 3'h5) ? 3'h0 : s + 3'h1;
            if (s == 3'h5 && lo != 5'h00) begin
                hp = s;
                do lp = (lp == 3'h4) ? 3'h0 : lp + 3'h1; while (!lo[lp]);
                return lp;
            end
            if (s != 3'h5 && rq[s] && ctl.enable[s] && ctl.high[s]) begin
                hp = s;
                return s;
            end
        end
        return 3'h7;
    endfunction : pick
    task automatic burst(input logic [4:0] m);
        logic [4:0] left;
        logic [2:0] w;
        left = m;
        last = 3'h7;
        w = pick(left);
        while (w != 3'h7) begin
            gnt_q.push_back(w);
            left[w] = 1'b0;
            last = w;
            w = pick(left);
        end
        want <= m;
        n = 0;
        while (gnt_q.size() != 0 && n++ < 400) @(posedge clk);
        repeat (6) @(posedge clk);
        if (last != 3'h7) check("park", g, 33'h1 << last);
        want <= 5'h00;
        repeat (IDLE_M + 6) @(posedge clk);
        check("idle", g, 33'h0);
    endtask : burst
    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        hp = 3'h0;
        lp = 3'h4;
        ctl = 10'h03F;
        repeat (4) @(posedge clk);
        if (s) gnt_q.push_back(3'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("drive", {req_n_o, req_oe_n, gnt_oe_n}, s ? 33'hFF0 : 33'hFEF);
    endtask : do_reset
    initial begin
        do_reset(1'b1);
        apb(1'b0, 8'h04, 32'h0, 33'h000004003);
        apb(1'b0, 8'h00, 32'h0, 33'h00000011F);
        apb(1'b0, 8'h08, 32'h0, 33'h100000000);
        repeat (IDLE_M + 4) @(posedge clk);
        check("idle", g, 33'h0);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            ctl = r[9:0];
            lag <= {r[10], 1'b0};
            apb(1'b1, 8'h00, {19'h0, ctl.high, 3'h0, ctl.enable}, 33'h0);
            apb(1'b0, 8'h00, 32'h0, {20'h0, ctl.high, 3'h0, ctl.enable});
            burst((i == 0) ? 5'h1F : r[20:16]);
            $display("burst %0d done", i);
        end
        do_reset(1'b0);
        want <= 5'h01;
        n = 0;
        while (req_pin[0] !== 1'b0 && n++ < 20) @(posedge clk);
        gnt_q.push_back(3'h0);
        ext_gnt_n <= 4'hE;
        n = 0;
        while (req[0] && n++ < 40) @(posedge clk);
        ext_gnt_n <= 4'hF;
        want <= 5'h00;
        repeat (4) @(posedge clk);
        check("queue", 33'(gnt_q.size()), 33'h0);
        $display("strap off test done");
        close_out();
    end
endmodule : tb_top
